// >>> psled_driver.sv
// Status LED driver: legacy and enhanced LED methods for a tri-speed transceiver
`timescale 1ns/1ps
// Behaviour
// - Method bit selects enhanced or legacy scheme
// - Enhanced scheme ignores legacy control inputs
// - Method bit resets to legacy scheme
// - LED pins are active low
// - Mode 0 link any speed, activity
// - Modes 1-3 qualify single speed
// - Modes 4-6 qualify speed pairs
// - Mode 8 full duplex, half-duplex collisions
// - Mode 9 shows collisions only
// - Mode 10 activity, optionally transmit only
// - Mode 12 shows auto-negotiation fault
// - Mode 14 off, mode 15 on
// - Per-pin mode from register or straps
// - Combine adds secondary indication to primary
// - Per-pin blink or stretch, 50% blink
// - Stretch holds on and off states
// - Blink rate 2.5, 5, 10, 20 Hz
// - Stretch length 50 to 400 ms
// - Pulsing modulates asserted pins 5 kHz, 20%
// - Activity counts transmit and receive frames, or transmit frames only when transmit-only is set
// - Four independent LED output pins
module psled_driver
    import psled_pkg::*;
#(
    parameter int unsigned BLINK_HALF  = BLINK_HALF_CYC,
    parameter int unsigned STRETCH_LEN = STRETCH_BASE_CYC,
    parameter int unsigned PULSE_PER   = PULSE_CYC,
    parameter int unsigned PULSE_ON    = PULSE_ON_CYC
) (
    input  wire logic                         mclk,
    input  wire logic                         resetn,
    input  wire logic                         method_wr,
    input  wire logic                         method_wdata,
    output logic                              method_sel,
    input  wire logic                         mode_from_strap,
    input  wire logic [NUM_LEDS*MODE_W-1:0]   mode_cfg,
    input  wire logic [NUM_LEDS*MODE_W-1:0]   config_strap_pins,
    input  wire logic [NUM_LEDS-1:0]          combine_en,
    input  wire logic [NUM_LEDS-1:0]          stretch_sel,
    input  wire logic [1:0]                   rate_sel,
    input  wire logic                         pulsing_en,
    input  wire logic                         tx_only_act,
    input  wire logic [NUM_LEDS-1:0]          legacy_led_n,
    input  wire logic                         link_up,
    input  wire logic [1:0]                   link_speed,
    input  wire logic                         full_duplex,
    input  wire logic                         tx_frame,
    input  wire logic                         rx_frame,
    input  wire logic                         collision,
    input  wire logic                         aneg_fault,
    output logic [NUM_LEDS-1:0]               led_n
);
    // ----------------------------------------------------------------
    // Method select
    // ----------------------------------------------------------------
    logic method_reg;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            method_reg <= METHOD_RESET;
        end else if (method_wr) begin
            method_reg <= method_wdata;
        end
    end
    assign method_sel = method_reg;

    // ----------------------------------------------------------------
    // Timebase dividers
    // ----------------------------------------------------------------
    // One stretch base unit of 50 ms; the fastest blink half period is an
    // eighth of the slowest, so both share divider structure.
    localparam int unsigned BH_W = $clog2(BLINK_HALF + 1);
    localparam int unsigned ST_W = $clog2(STRETCH_LEN * 8 + 1);
    localparam int unsigned PU_W = $clog2(PULSE_PER + 1);
    localparam logic [BH_W-1:0] BLINK_Q = BH_W'(BLINK_HALF / 8);
    localparam logic [ST_W-1:0] ST_UNIT = ST_W'(STRETCH_LEN);
    localparam logic [PU_W-1:0] PU_LAST = PU_W'(PULSE_PER - 1);
    localparam logic [PU_W-1:0] PU_ONC  = PU_W'(PULSE_ON);

    logic [BH_W-1:0] bdiv_reg;
    logic [3:0]      bphase_reg;
    logic [PU_W-1:0] pcnt_reg;
    wire             btick = (bdiv_reg == BLINK_Q - 1'b1);
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            bdiv_reg   <= '0;
            bphase_reg <= '0;
            pcnt_reg   <= '0;
        end else begin
            bdiv_reg   <= btick ? '0 : bdiv_reg + 1'b1;
            bphase_reg <= btick ? bphase_reg + 1'b1 : bphase_reg;
            pcnt_reg   <= (pcnt_reg == PU_LAST) ? '0 : pcnt_reg + 1'b1;
        end
    end
    // Phase bit 3 toggles at 2.5 Hz, bit 0 at 20 Hz
    wire blink_wave = bphase_reg[2'd3 - rate_sel];
    wire pulse_on   = (pcnt_reg < PU_ONC);
    wire [ST_W-1:0] st_len = ST_UNIT << rate_sel;

    // ----------------------------------------------------------------
    // Status decode
    // ----------------------------------------------------------------
    wire act_any  = tx_only_act ? tx_frame : (tx_frame | rx_frame);
    wire lk10     = link_up && (link_speed == PSLED_SPD_10);
    wire lk100    = link_up && (link_speed == PSLED_SPD_100);
    wire lk1000   = link_up && (link_speed == PSLED_SPD_1000);
    wire half_col = link_up && !full_duplex && collision;

    // ----------------------------------------------------------------
    // Per-pin logic
    // ----------------------------------------------------------------
    logic [NUM_LEDS-1:0]      stretch_st;
    logic [NUM_LEDS-1:0]      led_reg;
    logic [NUM_LEDS-1:0]      led_next;

    genvar g;
    generate
        for (g = 0; g < NUM_LEDS; g++) begin : g_pin
            wire [MODE_W-1:0] mode = mode_from_strap ?
                config_strap_pins[g*MODE_W +: MODE_W] :
                mode_cfg[g*MODE_W +: MODE_W];
            logic prim;
            logic sec;
            logic fixed;
            logic fixval;
            always_comb begin
                prim   = 1'b0;
                sec    = 1'b0;
                fixed  = 1'b0;
                fixval = 1'b0;
                unique case (mode)
                    4'h0: begin
                        prim = link_up;
                        sec  = act_any;
                    end
                    4'h1: begin
                        prim = lk1000;
                        sec  = act_any;
                    end
                    4'h2: begin
                        prim = lk100;
                        sec  = act_any;
                    end
                    4'h3: begin
                        prim = lk10;
                        sec  = act_any;
                    end
                    4'h4: begin
                        prim = lk100 | lk1000;
                        sec  = act_any;
                    end
                    4'h5: begin
                        prim = lk10 | lk1000;
                        sec  = act_any;
                    end
                    4'h6: begin
                        prim = lk10 | lk100;
                        sec  = act_any;
                    end
                    4'h8: begin
                        prim = link_up & full_duplex;
                        sec  = half_col;
                    end
                    4'h9: begin
                        sec  = collision;
                    end
                    4'ha: begin
                        sec  = act_any;
                    end
                    4'hc: begin
                        fixed  = 1'b1;
                        fixval = aneg_fault;
                    end
                    4'he: begin
                        fixed  = 1'b1;
                        fixval = 1'b0;
                    end
                    4'hf: begin
                        fixed  = 1'b1;
                        fixval = 1'b1;
                    end
                    default: begin
                        fixed  = 1'b1;
                        fixval = 1'b0;
                    end
                endcase
            end
            // Modes 9 and 10 have only a secondary; combine is implied there
            wire sec_only = (mode == 4'h9) || (mode == 4'ha);
            // A stale stretched state must not light a pin whose link is gone
            wire sec_lnk  = (mode <= 4'h6) ? prim :
                            (mode == 4'h8) ? (link_up && !full_duplex) : 1'b1;
            wire sec_gate = sec_lnk && (combine_en[g] || sec_only);
            wire sec_vis  = sec && sec_gate;

            // Stretch: each state, once entered, holds for the full length
            logic            hold_reg;
            logic [ST_W-1:0] hold_cnt_reg;
            wire             st_busy = (hold_cnt_reg != '0);
            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    hold_reg     <= 1'b0;
                    hold_cnt_reg <= '0;
                end else if (!st_busy && (sec_vis != hold_reg)) begin
                    hold_reg     <= sec_vis;
                    hold_cnt_reg <= st_len;
                end else if (st_busy) begin
                    hold_cnt_reg <= hold_cnt_reg - 1'b1;
                end
            end
            assign stretch_st[g] = hold_reg;
            // Over a lit link the stretched activity shows as a dark pulse
            wire st_show  = hold_reg && (!prim || sec_only);
            wire act_show = stretch_sel[g] ? st_show : blink_wave;
            wire sec_on   = stretch_sel[g] ? (hold_reg && sec_gate) : sec_vis;
            wire enh_on   = fixed ? fixval : (sec_on ? act_show : prim);
            wire base_on  = method_reg ? enh_on : !legacy_led_n[g];
            assign led_next[g] = !(base_on && (!pulsing_en || pulse_on));
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            led_reg <= {NUM_LEDS{LED_OFF}};
        end else begin
            led_reg <= led_next;
        end
    end
    assign led_n = led_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_method_reset: assert property (@(posedge mclk)
        !resetn |=> !method_reg) else $error("method bit not cleared by reset");
    a_method_write: assert property (@(posedge mclk) disable iff (!resetn)
        method_wr |=> (method_reg == $past(method_wdata)))
        else $error("method bit did not take write");
    a_legacy_pass: assert property (@(posedge mclk) disable iff (!resetn)
        !method_reg && !pulsing_en |=> led_n == $past(legacy_led_n))
        else $error("legacy path not followed");
    a_force_off: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'he |=> led_n[0])
        else $error("forced off pin asserted");
    a_force_on: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'hf && !pulsing_en
        |=> !led_n[0]) else $error("forced on pin not asserted");
    a_reserved_off: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h7 |=> led_n[0])
        else $error("reserved mode pin asserted");
    a_pulse_duty: assert property (@(posedge mclk) disable iff (!resetn)
        pulsing_en && !pulse_on |=> &led_n) else $error("pulse off phase drives led");
    a_no_link: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h0 && !link_up |=> led_n[0])
        else $error("mode 0 lit without link");
    a_aneg_led: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'hc && !pulsing_en
        |=> led_n[0] == !$past(aneg_fault)) else $error("fault led wrong");
    a_reset_off: assert property (@(posedge mclk)
        !resetn |=> &led_n) else $error("led asserted after reset");

    // Pin 0 stands for all pins; the others share the same generate body
    a_method_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !method_wr |=> $stable(method_reg))
        else $error("method bit moved without write");
    a_strap_select: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && mode_from_strap && config_strap_pins[3:0] == 4'he |=> led_n[0])
        else $error("strap off mode ignored");
    a_strap_on: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && mode_from_strap && config_strap_pins[3:0] == 4'hf && !pulsing_en
        |=> !led_n[0]) else $error("strap on mode ignored");
    a_mode8_full: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h8 && link_up && full_duplex
        && !pulsing_en |=> !led_n[0]) else $error("full duplex not shown");
    a_mode8_half: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h8 && (!link_up ||
        (!full_duplex && !collision && !stretch_sel[0])) |=> led_n[0])
        else $error("half duplex or no link lit");
    a_mode9_quiet: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h9 && !collision
        && !stretch_sel[0] |=> led_n[0]) else $error("collision led lit when quiet");
    a_mode10_tx: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'ha && tx_only_act
        && !tx_frame && !stretch_sel[0] |=> led_n[0]) else $error("receive shown in tx mode");
    a_combine_off: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h0 && !combine_en[0]
        && link_up && !pulsing_en |=> !led_n[0]) else $error("activity shown uncombined");
    a_mode1_off: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h1
        && !(link_up && link_speed == 2'd2) |=> led_n[0]) else $error("mode 1 wrong speed lit");
    a_mode1_lit: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h1 && link_up && link_speed == 2'd2
        && !combine_en[0] && !pulsing_en |=> !led_n[0]) else $error("mode 1 link dark");
    a_mode2_off: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h2
        && link_speed != 2'd1 |=> led_n[0]) else $error("mode 2 wrong speed lit");
    a_mode3_off: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h3
        && link_speed != 2'd0 |=> led_n[0]) else $error("mode 3 wrong speed lit");
    a_mode3_lit: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h3 && link_up && link_speed == 2'd0
        && !combine_en[0] && !pulsing_en |=> !led_n[0]) else $error("mode 3 link dark");
    a_mode4_off: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h4
        && link_speed == 2'd0 |=> led_n[0]) else $error("mode 4 lit at 10");
    a_mode5_off: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h5
        && link_speed == 2'd1 |=> led_n[0]) else $error("mode 5 lit at 100");
    a_mode6_off: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h6
        && link_speed == 2'd2 |=> led_n[0]) else $error("mode 6 lit at 1000");
    a_mode6_lit: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'h6 && link_up && link_speed == 2'd0
        && !combine_en[0] && !pulsing_en |=> !led_n[0]) else $error("mode 6 link dark");
    a_reserved_b: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'hb |=> led_n[0])
        else $error("reserved mode 11 lit");
    a_reserved_d: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'hd |=> led_n[0])
        else $error("reserved mode 13 lit");
    a_pulse_on: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'hf && pulsing_en && pulse_on
        |=> !led_n[0]) else $error("pulse on phase dark");
    a_tx_counts: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'ha && !stretch_sel[0] && tx_frame
        && blink_wave && !pulsing_en |=> !led_n[0]) else $error("transmit not shown");
    a_rx_counts: assert property (@(posedge mclk) disable iff (!resetn)
        method_reg && !mode_from_strap && mode_cfg[3:0] == 4'ha && !stretch_sel[0] && rx_frame
        && !tx_only_act && blink_wave && !pulsing_en |=> !led_n[0]) else $error("receive lost");
    // Stretch checks assume a stretch unit of at least eight cycles
    a_stretch_on: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(stretch_st[0]) |=> stretch_st[0] [*8])
        else $error("stretched on state cut short");
    a_stretch_off: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(stretch_st[0]) |=> !stretch_st[0] [*8])
        else $error("stretched off state cut short");

    // ----------------------------------------------------------------
    // Cover points
    // ----------------------------------------------------------------
    c_enhanced: cover property (@(posedge mclk) method_wr && method_wdata);
    c_stretch:  cover property (@(posedge mclk) stretch_st[0] && stretch_sel[0]);
    c_collide:  cover property (@(posedge mclk) method_reg && collision && !led_n[0]);
    c_blink:    cover property (@(posedge mclk) $rose(blink_wave));
    c_pulsing:  cover property (@(posedge mclk) pulsing_en && !led_n[0]);
endmodule

// >>> psled_pkg.sv
// Package: constants and types for the status LED driver
package psled_pkg;
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned NUM_LEDS        = 4;
    localparam int unsigned MODE_W          = 4;
    // Blink frequencies in centi-hertz: 2.5, 5, 10, 20 Hz
    localparam int unsigned BLINK_CHZ_0     = 250;
    localparam int unsigned BLINK_CHZ_1     = 500;
    localparam int unsigned BLINK_CHZ_2     = 1000;
    localparam int unsigned BLINK_CHZ_3     = 2000;
    // Half period of the slowest blink, in cycles
    localparam int unsigned BLINK_HALF_CYC  = CLK_HZ * 50 / BLINK_CHZ_0;
    // Pulse-stretch lengths in ms: 50, 100, 200, 400
    localparam int unsigned STRETCH_MS_0    = 50;
    localparam int unsigned STRETCH_BASE_CYC = CLK_HZ / 1000 * STRETCH_MS_0;
    // Pulsing: 5 kHz, 20% asserted
    localparam int unsigned PULSE_HZ        = 5000;
    localparam int unsigned PULSE_PCT       = 20;
    localparam int unsigned PULSE_CYC       = CLK_HZ / PULSE_HZ;
    localparam int unsigned PULSE_ON_CYC    = PULSE_CYC * PULSE_PCT / 100;
    localparam logic        METHOD_RESET    = 1'b0;
    localparam logic        LED_OFF         = 1'b1;
    localparam logic        LED_ON          = 1'b0;
    typedef enum logic [1:0] {
        PSLED_SPD_10,
        PSLED_SPD_100,
        PSLED_SPD_1000,
        PSLED_SPD_NONE
    } psled_speed_t;
endpackage

// >>> psled_led_model.sv
// Board LED model: four discrete LEDs lit by a low pin
`timescale 1ns/1ps
module psled_led_model
    import psled_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic [NUM_LEDS-1:0] led_n,
    output logic      [NUM_LEDS-1:0] lit
);
    // Cathode sinks current, so a low pin lights the LED
    assign lit = ~led_n;
endmodule

// >>> psled_driver_tb_top.sv
// Self-checking testbench for the status LED driver
`timescale 1ns/1ps
module psled_driver_tb_top;
    import psled_pkg::*;
    localparam int BH = 64, SL = 16, PP = 10, PO = 2;
    logic mclk = 1'b0, resetn = 1'b0, method_wr = 1'b0, method_wdata = 1'b0, method_sel;
    logic mode_from_strap = 1'b0, pulsing_en = 1'b0, tx_only_act = 1'b0, link_up = 1'b0;
    logic full_duplex = 1'b0, tx_frame = 1'b0, rx_frame = 1'b0, collision = 1'b0;
    logic aneg_fault = 1'b0;
    logic [15:0] mode_cfg = 16'h0000, config_strap_pins = 16'h0000;
    logic [3:0]  combine_en = 4'h0, stretch_sel = 4'h0, legacy_led_n = 4'hf, led_n, lit;
    logic [1:0]  rate_sel = 2'h0, link_speed = 2'h0;
    logic [15:0] m;
    logic [3:0]  e;
    int          bad_count = 0, n_compared = 0, g1, g2, c;
    always #12.5 mclk = ~mclk;
    psled_driver #(
        .BLINK_HALF(BH), .STRETCH_LEN(SL), .PULSE_PER(PP), .PULSE_ON(PO)
    ) u_psled_driver (
        .mclk(mclk), .resetn(resetn), .method_wr(method_wr), .method_wdata(method_wdata),
        .method_sel(method_sel), .mode_from_strap(mode_from_strap), .mode_cfg(mode_cfg),
        .config_strap_pins(config_strap_pins), .combine_en(combine_en),
        .stretch_sel(stretch_sel), .rate_sel(rate_sel), .pulsing_en(pulsing_en),
        .tx_only_act(tx_only_act), .legacy_led_n(legacy_led_n), .link_up(link_up),
        .link_speed(link_speed), .full_duplex(full_duplex), .tx_frame(tx_frame),
        .rx_frame(rx_frame), .collision(collision), .aneg_fault(aneg_fault), .led_n(led_n));
    psled_led_model u_psled_led_model (.mclk(mclk), .led_n(led_n), .lit(lit));
    // --------------------------------------------------------------
    // Expectation and helpers
    // --------------------------------------------------------------
    function automatic logic exp_pin(input logic [3:0] md);
        logic [2:0] mk [7];
        mk = '{3'b111, 3'b100, 3'b010, 3'b001, 3'b110, 3'b101, 3'b011};
        // Quiet traffic, so only the primary status shows
        if (md < 4'h7) return ~(link_up && mk[md][link_speed]);
        if (md == 4'h8) return ~(link_up && full_duplex);
        if (md == 4'hc) return ~aneg_fault;
        return (md != 4'hf);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask
    // Half-period measure; first call after a setting change is partial
    task automatic edge_gap(output int g);
        logic v;
        g = 1;
        v = led_n[0];
        @(negedge mclk);
        while (led_n[0] === v && g < 1000) begin
            g++;
            @(negedge mclk);
        end
    endtask
    task automatic count_lit(input int n, output int k);
        k = 0;
        repeat (n) begin
            @(negedge mclk);
            k += (lit[0] === 1'b1);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        void'($urandom(25872));
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        @(negedge mclk);
        check(method_sel, 0, "method after reset");
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            legacy_led_n <= 4'($urandom);
            settle();
            check(led_n, legacy_led_n, "legacy pins");
        end
        @(posedge mclk);
        method_wr <= 1'b1;
        method_wdata <= 1'b1;
        @(posedge mclk);
        method_wr <= 1'b0;
        settle();
        check(method_sel, 1, "method write");
        $display("method test done");
        for (int i = 0; i < 60; i++) begin
            @(posedge mclk);
            mode_cfg <= 16'($urandom);
            config_strap_pins <= 16'($urandom);
            mode_from_strap <= 1'($urandom);
            legacy_led_n <= 4'($urandom);
            link_up <= 1'($urandom);
            link_speed <= 2'($urandom_range(0, 2));
            full_duplex <= 1'($urandom);
            aneg_fault <= 1'($urandom);
            settle();
            m = mode_from_strap ? config_strap_pins : mode_cfg;
            for (int p = 0; p < 4; p++) e[p] = exp_pin(m[4*p+:4]);
            check(led_n, e, "static modes");
        end
        $display("static mode test done");
        @(posedge mclk);
        mode_from_strap <= 1'b0;
        mode_cfg <= 16'haaaa;
        tx_frame <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            @(posedge mclk);
            rate_sel <= 2'(r);
            repeat (150) @(posedge mclk);
            edge_gap(g1);
            edge_gap(g1);
            edge_gap(g2);
            check(g1, BH >> r, "blink half period");
            check(g2, BH >> r, "blink duty");
        end
        // Link up at the last random speed plus traffic: combine decides whether it blinks
        @(posedge mclk);
        mode_cfg <= 16'h0000;
        link_up <= 1'b1;
        combine_en <= 4'h0;
        settle();
        count_lit(100, c);
        check(c, 100, "combine off steady");
        @(posedge mclk);
        combine_en <= 4'hf;
        settle();
        count_lit(100, c);
        check(c < 100, 1, "combine on blinks");
        @(posedge mclk);
        mode_cfg <= 16'h9999;
        collision <= 1'b1;
        settle();
        count_lit(64, c);
        check(c, 32, "collision blink");
        $display("blink test done");
        @(posedge mclk);
        mode_cfg <= 16'haaaa;
        tx_frame <= 1'b0;
        collision <= 1'b0;
        stretch_sel <= 4'hf;
        for (int r = 0; r < 5; r++) begin
            @(posedge mclk);
            rate_sel <= 2'(r % 4);
            tx_only_act <= (r == 4);
            repeat (400) @(posedge mclk);
            rx_frame <= 1'b1;
            @(posedge mclk);
            rx_frame <= 1'b0;
            count_lit(600, c);
            if (r < 4) check(c >= (SL << r), 1, "stretch length");
            else check(c, 0, "transmit only");
        end
        $display("stretch test done");
        @(posedge mclk);
        mode_cfg <= 16'hffff;
        pulsing_en <= 1'b1;
        settle();
        count_lit(10 * PP, c);
        check(c, 10 * PO, "pulsing duty");
        $display("pulsing test done");
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check({method_sel, led_n}, 5'h0f, "second reset");
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        $display("FAIL t=%0t watchdog expired", $time);
        end_sim();
    end
endmodule
